// file: bench/ctl_model.sv
/*
  Remote controller model: issues commands and serial polls.
  Assumes the device answers one cycle after each request.
*/
module ctl_model (
  input wire logic ref_clk_in,
  input wire logic rsp_valid_in,
  input wire logic [7:0] rsp_value_in,
  input wire logic [11:0] rsp_bcd_in,
  input wire logic poll_valid_in,
  input wire logic [7:0] poll_byte_in,
  input wire logic oq_flush_in,
  output logic cmd_valid_out,
  output logic [3:0] cmd_code_out,
  output logic [7:0] cmd_data_out,
  output logic spoll_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic got_v;
  logic [7:0] got;
  logic [11:0] got_bcd;
  logic got_fl;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out = 4'h0;
    cmd_data_out = 8'h00;
    spoll_out = 1'b0;
  end

  // =====
  // Command and serial poll tasks
  task automatic send(input logic [3:0] c, input logic [7:0] d);
    @(posedge ref_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out <= c;
    cmd_data_out <= d;
    @(posedge ref_clk_in);
    cmd_valid_out <= 1'b0;
    cmd_data_out <= ~d;
    #1;
    got_v = rsp_valid_in;
    got = rsp_value_in;
    got_bcd = rsp_bcd_in;
    got_fl = oq_flush_in;
  endtask

  task automatic poll;
    @(posedge ref_clk_in);
    spoll_out <= 1'b1;
    @(posedge ref_clk_in);
    spoll_out <= 1'b0;
    #1;
    got_v = poll_valid_in;
    got = poll_byte_in;
  endtask
endmodule

// file: bench/status_asserts.sv
/*
  Port checker for the status reporting block.
  Assumes it is bound to the status reporting block and shares its clock and reset.
*/
module status_asserts (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic spoll_in,
  input wire logic oq_not_empty_in,
  input wire logic rsp_valid_out,
  input wire logic [7:0] rsp_value_out,
  input wire logic [11:0] rsp_bcd_out,
  input wire logic poll_valid_out,
  input wire logic [7:0] poll_byte_out,
  input wire logic [7:0] status_byte_out,
  input wire logic oq_flush_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [7:0] srq_mask_q;
  wire logic isq = cmd_valid_in && (cmd_code_in inside {4'h3, 4'h4, 4'h6,
    4'h7});

  // Shadow of the service request mask
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      srq_mask_q <= 8'h00;
    end else if (cmd_valid_in && cmd_code_in == 4'h5) begin
      srq_mask_q <= cmd_data_in;
    end
  end

  function automatic logic [11:0] to_bcd(input logic [7:0] v);
    to_bcd = {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
  endfunction

  // =====
  // Assertions
  unused_zero_a: assert property (
    status_byte_out[3:0] == 4'h0 && !status_byte_out[7])
    else $error("unused summary bits set");
  mav_track_a: assert property (
    status_byte_out[4] == $past(oq_not_empty_in))
    else $error("message flag off the queue state");
  query_answer_a: assert property (
    rsp_valid_out == $past(isq))
    else $error("answer strobe not one cycle after query");
  answer_decimal_a: assert property (
    rsp_valid_out |-> rsp_bcd_out == to_bcd(rsp_value_out))
    else $error("decimal answer wrong");
  srq_readback_a: assert property (
    cmd_valid_in && cmd_code_in == 4'h6
    |=> rsp_value_out == ($past(srq_mask_q) & 8'hbf))
    else $error("request mask readback wrong");
  master_summary_a: assert property (
    status_byte_out[6] == |(status_byte_out & 8'h30 & $past(srq_mask_q)))
    else $error("master summary wrong");
  clear_flush_a: assert property (
    cmd_valid_in && cmd_code_in == 4'h1 |=> oq_flush_out)
    else $error("no queue flush on clear");
  poll_form_a: assert property (
    spoll_in |=> poll_valid_out && poll_byte_out[3:0] == 4'h0 &&
    !poll_byte_out[7] && poll_byte_out[5:4] == status_byte_out[5:4])
    else $error("poll answer wrong");

  poll_rqs_c: cover property (spoll_in ##1 poll_byte_out[6]);
  mss_c: cover property (status_byte_out[6]);
  flush_c: cover property (oq_flush_out);
endmodule

bind status_reporting_service_request status_asserts chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
  .cmd_data_in(cmd_data_in), .spoll_in(spoll_in),
  .oq_not_empty_in(oq_not_empty_in), .rsp_valid_out(rsp_valid_out),
  .rsp_value_out(rsp_value_out), .rsp_bcd_out(rsp_bcd_out),
  .poll_valid_out(poll_valid_out), .poll_byte_out(poll_byte_out),
  .status_byte_out(status_byte_out), .oq_flush_out(oq_flush_out)
);

// file: bench/tb_top.sv
/*
  Self-checking testbench for the status reporting block.
  Assumes the controller model and the bound port checker.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ops_pending = 1'b0;
  logic oq_not_empty = 1'b0;
  logic oq_pending = 1'b0;
  logic [4:0] ev = 5'h00;
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic [7:0] cmd_data;
  logic spoll;
  logic rsp_valid;
  logic [7:0] rsp_value;
  logic [11:0] rsp_bcd;
  logic poll_valid;
  logic [7:0] poll_byte;
  logic [7:0] status_byte;
  logic srq;
  logic oq_flush;
  logic opc_busy;
  int fails = 0;
  int cmp_count = 0;
  int i;

  always #4 ref_clk = ~ref_clk;

  status_reporting_service_request dut (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .cmd_valid_in(cmd_valid),
    .cmd_code_in(cmd_code), .cmd_data_in(cmd_data), .spoll_in(spoll),
    .ops_pending_in(ops_pending), .oq_not_empty_in(oq_not_empty),
    .oq_pending_in(oq_pending), .oq_read_in(ev[0]), .dev_err_in(ev[1]),
    .exec_err_in(ev[2]), .cmd_err_in(ev[3]), .local_ctrl_in(ev[4]),
    .rsp_valid_out(rsp_valid), .rsp_value_out(rsp_value),
    .rsp_bcd_out(rsp_bcd), .poll_valid_out(poll_valid),
    .poll_byte_out(poll_byte), .status_byte_out(status_byte),
    .srq_out(srq), .oq_flush_out(oq_flush), .opc_busy_out(opc_busy));

  ctl_model ctl (
    .ref_clk_in(ref_clk), .rsp_valid_in(rsp_valid),
    .rsp_value_in(rsp_value), .rsp_bcd_in(rsp_bcd),
    .poll_valid_in(poll_valid), .poll_byte_in(poll_byte),
    .oq_flush_in(oq_flush), .cmd_valid_out(cmd_valid),
    .cmd_code_out(cmd_code), .cmd_data_out(cmd_data), .spoll_out(spoll));

  // =====
  // Helpers
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t byte %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk12(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t digits %h exp %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Pulse {local, cmd, exec, dev, queue read}
  task automatic pulse(input logic [4:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 5'h00;
  endtask

  task automatic ask(input logic [3:0] c, input logic [7:0] e,
    input logic [11:0] b);
    ctl.send(c, 8'h00);
    chk8({7'h00, ctl.got_v}, 8'h01);
    chk8(ctl.got, e);
    chk12(ctl.got_bcd, b);
  endtask

  // =====
  // Scenarios
  task automatic s_power;
    ask(4'h4, 8'h80, 12'h128); // power-on bit reads back
    ask(4'h4, 8'h00, 12'h000); // cleared by the read
  endtask

  task automatic s_masks;
    ctl.send(4'h2, 8'hff);
    ask(4'h3, 8'hff, 12'h255); // event mask readback
    ctl.send(4'h5, 8'hff);
    ask(4'h6, 8'hbf, 12'h191); // bit 6 dropped
    ctl.send(4'h1, 8'h00);
    ask(4'h3, 8'hff, 12'h255); // kept by clear-status
    ask(4'h6, 8'hbf, 12'h191); // kept by read
    ctl.send(4'h2, 8'h00);
    ask(4'h3, 8'h00, 12'h000); // zero clears
    ctl.send(4'h5, 8'h00);
    ask(4'h6, 8'h00, 12'h000); // zero clears
  endtask

  task automatic s_events;
    pulse(5'h1f);
    pulse(5'h1f);
    ctl.send(4'h9, 8'h00);
    ctl.send(4'ha, 8'h00);
    ask(4'h4, 8'h7c, 12'h124); // held through clears
    ctl.send(4'hf, 8'h00);
    ask(4'h4, 8'h20, 12'h032); // unknown command flagged
    @(posedge ref_clk);
    oq_pending <= 1'b1;
    pulse(5'h01);
    ask(4'h4, 8'h00, 12'h000); // no error while reply pending
    @(posedge ref_clk);
    oq_pending <= 1'b0;
  endtask

  task automatic s_summary;
    ctl.send(4'h2, 8'h20);
    ctl.send(4'h5, 8'h30);
    ctl.send(4'hf, 8'h00);
    tick(4);
    chk8(status_byte, 8'h60); // enabled event summary
    chk8({7'h00, srq}, 8'h01); // service request raised
    @(posedge ref_clk);
    oq_not_empty <= 1'b1;
    tick(3);
    chk8(status_byte, 8'h70); // queue holds data
    ask(4'h7, 8'h70, 12'h112); // status query
    ask(4'h7, 8'h70, 12'h112); // query leaves byte alone
    ctl.poll;
    chk8({7'h00, ctl.got_v}, 8'h01); // poll answered
    chk8(ctl.got, 8'h70); // request form in poll
    chk8({7'h00, srq}, 8'h00); // poll withdraws request
    ctl.poll;
    chk8(ctl.got, 8'h30); // master form not polled
    ctl.send(4'h1, 8'h00);
    chk8({7'h00, ctl.got_fl}, 8'h01); // queue discarded
    @(posedge ref_clk);
    oq_not_empty <= 1'b0;
    tick(3);
    chk8(status_byte, 8'h00); // summary follows clear
    ctl.send(4'h5, 8'hcf);
    @(posedge ref_clk);
    oq_not_empty <= 1'b1;
    tick(3);
    chk8(status_byte, 8'h10); // other mask bits idle
    @(posedge ref_clk);
    oq_not_empty <= 1'b0;
  endtask

  task automatic s_opc;
    ctl.send(4'h2, 8'h01);
    @(posedge ref_clk);
    ops_pending <= 1'b1;
    ctl.send(4'h8, 8'h00);
    tick(3);
    chk8({7'h00, opc_busy}, 8'h01); // waits on pending work
    chk8(status_byte, 8'h00); // no completion yet
    @(posedge ref_clk);
    ops_pending <= 1'b0;
    tick(0);
    for (i = 0; i < 20 && opc_busy !== 1'b0; i++) begin
      tick(1);
    end
    if (i == 20) begin
      fails++;
      $display("MISMATCH %0t completion wait timed out", $time);
      final_report;
    end
    tick(2);
    chk8(status_byte, 8'h20); // enabled bit reaches summary
    ask(4'h4, 8'h01, 12'h001); // completion flagged
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_power;
    s_masks;
    s_events;
    s_summary;
    s_opc;
    final_report;
  end
endmodule

// file: logic/event_latch.sv
/*
  Sticky event register, one flip-flop per bit.
  Assumes set requests are one-cycle pulses or levels from the owner.
*/
module event_latch #(
  parameter int unsigned WIDTH = status_pkg::BYTE_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  event_if.store ev
);

  // ==========================================================
  // Per-bit latches
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ev.held[i] <= status_pkg::EVENT_RESET[i];
        end else if (ev.set_bits[i]) begin
          ev.held[i] <= 1'b1;
        end else if (ev.clear) begin
          ev.held[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// file: logic/status_reporting_service_request.sv
/*
  Status reporting and service request logic: standard event register
  with its mask, status summary byte, service request mask, request
  service flag and serial poll answer.
  Assumes the command parser delivers decoded commands as one-cycle
  strobes and that error and local-control inputs are one-cycle pulses.
*/
module status_reporting_service_request (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic spoll_in,
  input wire logic ops_pending_in,
  input wire logic oq_not_empty_in,
  input wire logic oq_pending_in,
  input wire logic oq_read_in,
  input wire logic dev_err_in,
  input wire logic exec_err_in,
  input wire logic cmd_err_in,
  input wire logic local_ctrl_in,
  output logic rsp_valid_out,
  output logic [7:0] rsp_value_out,
  output logic [11:0] rsp_bcd_out,
  output logic poll_valid_out,
  output logic [7:0] poll_byte_out,
  output logic [7:0] status_byte_out,
  output logic srq_out,
  output logic oq_flush_out,
  output logic opc_busy_out
);

  // ==========================================================
  // Decimal conversion
  function automatic logic [11:0] to_bcd(input logic [7:0] v);
    logic [7:0] hund;
    logic [7:0] rest;
    logic [7:0] tens;
    logic [7:0] ones;
    hund = v / status_pkg::DEC_HUNDRED;
    rest = v % status_pkg::DEC_HUNDRED;
    tens = rest / status_pkg::DEC_TEN;
    ones = rest % status_pkg::DEC_TEN;
    return {hund[3:0], tens[3:0], ones[3:0]};
  endfunction

  // ==========================================================
  // Command decode
  status_pkg::cmd_t cmd;
  logic do_clear_status;
  logic do_event_mask_wr;
  logic do_event_mask_rd;
  logic do_event_rd;
  logic do_srq_mask_wr;
  logic do_srq_mask_rd;
  logic do_status_rd;
  logic do_op_complete;
  logic do_device_clear;
  logic bad_cmd;

  assign cmd = status_pkg::cmd_t'(cmd_code_in);

  always_comb begin
    do_clear_status = 1'b0;
    do_event_mask_wr = 1'b0;
    do_event_mask_rd = 1'b0;
    do_event_rd = 1'b0;
    do_srq_mask_wr = 1'b0;
    do_srq_mask_rd = 1'b0;
    do_status_rd = 1'b0;
    do_op_complete = 1'b0;
    do_device_clear = 1'b0;
    bad_cmd = 1'b0;
    if (cmd_valid_in) begin
      unique case (cmd)
        status_pkg::CMD_CLEAR_STATUS: begin
          do_clear_status = 1'b1;
        end
        status_pkg::CMD_EVENT_MASK_WR: begin
          do_event_mask_wr = 1'b1;
        end
        status_pkg::CMD_EVENT_MASK_RD: begin
          do_event_mask_rd = 1'b1;
        end
        status_pkg::CMD_EVENT_RD: begin
          do_event_rd = 1'b1;
        end
        status_pkg::CMD_SRQ_MASK_WR: begin
          do_srq_mask_wr = 1'b1;
        end
        status_pkg::CMD_SRQ_MASK_RD: begin
          do_srq_mask_rd = 1'b1;
        end
        status_pkg::CMD_STATUS_RD: begin
          do_status_rd = 1'b1;
        end
        status_pkg::CMD_OP_COMPLETE: begin
          do_op_complete = 1'b1;
        end
        status_pkg::CMD_RESET: begin
        end
        status_pkg::CMD_DEVICE_CLEAR: begin
          do_device_clear = 1'b1;
        end
        default: begin
          bad_cmd = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Mask registers
  logic [7:0] event_mask_q;
  logic [7:0] service_request_mask_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_mask_q <= status_pkg::EVENT_MASK_RESET;
    end else if (do_event_mask_wr) begin
      event_mask_q <= cmd_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      service_request_mask_q <= status_pkg::SRQ_MASK_RESET;
    end else if (do_srq_mask_wr) begin
      service_request_mask_q <= cmd_data_in & status_pkg::SRQ_WRITE_MASK;
    end
  end

  // ==========================================================
  // Operation complete tracking
  status_pkg::opc_state_t opc_state_q;
  status_pkg::opc_state_t opc_state_d;
  logic opc_done;

  always_comb begin
    opc_state_d = opc_state_q;
    opc_done = 1'b0;
    unique case (opc_state_q)
      status_pkg::OPC_IDLE: begin
        if (do_op_complete) begin
          opc_state_d = status_pkg::OPC_WAIT;
        end
      end
      status_pkg::OPC_WAIT: begin
        if (do_clear_status || do_device_clear) begin
          opc_state_d = status_pkg::OPC_IDLE;
        end else if (!ops_pending_in) begin
          opc_done = 1'b1;
          opc_state_d = status_pkg::OPC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opc_state_q <= status_pkg::OPC_IDLE;
    end else begin
      opc_state_q <= opc_state_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opc_busy_out <= 1'b0;
    end else begin
      opc_busy_out <= (opc_state_d == status_pkg::OPC_WAIT);
    end
  end

  // ==========================================================
  // Power-on marker
  logic power_on_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_on_q <= 1'b1;
    end else begin
      power_on_q <= 1'b0;
    end
  end

  // ==========================================================
  // Standard event register
  event_if ev_bus ();
  logic [7:0] ev_set;
  logic query_err;

  assign query_err = oq_read_in && !oq_not_empty_in && !oq_pending_in;

  always_comb begin
    ev_set = status_pkg::EVENT_RESET;
    ev_set[status_pkg::EV_OPC] = opc_done;
    ev_set[status_pkg::EV_REQ_CTRL] = 1'b0;
    ev_set[status_pkg::EV_QUERY_ERR] = query_err;
    ev_set[status_pkg::EV_DEV_ERR] = dev_err_in;
    ev_set[status_pkg::EV_EXEC_ERR] = exec_err_in;
    ev_set[status_pkg::EV_CMD_ERR] = cmd_err_in || bad_cmd;
    ev_set[status_pkg::EV_USER_REQ] = local_ctrl_in;
    ev_set[status_pkg::EV_POWER_ON] = power_on_q;
  end

  assign ev_bus.set_bits = ev_set;
  assign ev_bus.clear = do_event_rd || do_clear_status;

  event_latch #(
    .WIDTH(status_pkg::BYTE_W)
  ) u_event_latch (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ev(ev_bus)
  );

  // ==========================================================
  // Summary byte
  logic mav;
  logic esb;
  logic mss;
  logic [7:0] summary_core;
  logic [7:0] summary_full;

  assign mav = oq_not_empty_in;
  assign esb = |(ev_bus.held & event_mask_q);

  always_comb begin
    summary_core = status_pkg::BYTE_ZERO;
    summary_core[status_pkg::SB_MAV] = mav;
    summary_core[status_pkg::SB_ESB] = esb;
  end

  // Only bits 4 and 5 count
  assign mss = |(summary_core & service_request_mask_q &
                 status_pkg::SRQ_ACTIVE_MASK);

  always_comb begin
    summary_full = summary_core;
    summary_full[status_pkg::SB_RQS] = mss;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_byte_out <= status_pkg::BYTE_ZERO;
    end else begin
      status_byte_out <= summary_full;
    end
  end

  // ==========================================================
  // Request service flag
  logic mss_prev_q;
  logic rqs_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mss_prev_q <= 1'b0;
    end else begin
      mss_prev_q <= mss;
    end
  end

  // New reason sets, poll clears, set wins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rqs_q <= 1'b0;
    end else if (mss && !mss_prev_q) begin
      rqs_q <= 1'b1;
    end else if (spoll_in || !mss) begin
      rqs_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      srq_out <= 1'b0;
    end else begin
      srq_out <= rqs_q && !spoll_in || (mss && !mss_prev_q);
    end
  end

  // ==========================================================
  // Serial poll answer
  // Poll carries request form
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      poll_valid_out <= 1'b0;
      poll_byte_out <= status_pkg::BYTE_ZERO;
    end else begin
      poll_valid_out <= spoll_in;
      if (spoll_in) begin
        poll_byte_out <= summary_core |
          ({7'h00, rqs_q} << status_pkg::SB_RQS);
      end
    end
  end

  // ==========================================================
  // Query answers
  logic rsp_hit;
  logic [7:0] rsp_value;

  always_comb begin
    rsp_hit = 1'b1;
    rsp_value = status_pkg::BYTE_ZERO;
    if (do_event_mask_rd) begin
      rsp_value = event_mask_q;
    end else if (do_event_rd) begin
      rsp_value = ev_bus.held;
    end else if (do_srq_mask_rd) begin
      rsp_value = service_request_mask_q;
    end else if (do_status_rd) begin
      rsp_value = summary_full;
    end else begin
      rsp_hit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_valid_out <= 1'b0;
      rsp_value_out <= status_pkg::BYTE_ZERO;
      rsp_bcd_out <= status_pkg::BCD_ZERO;
    end else begin
      rsp_valid_out <= rsp_hit;
      if (rsp_hit) begin
        rsp_value_out <= rsp_value;
        rsp_bcd_out <= to_bcd(rsp_value);
      end
    end
  end

  // ==========================================================
  // Output queue flush
  // Clear-status discards replies
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oq_flush_out <= 1'b0;
    end else begin
      oq_flush_out <= do_clear_status || do_device_clear;
    end
  end

endmodule

// file: shared/event_if.sv
/*
  Carrier between the status block and its standard event latch.
  Assumes both ends run on the same clock.
*/
interface event_if;
  logic [7:0] set_bits;
  logic clear;
  logic [7:0] held;

  modport ctrl (
    output set_bits,
    output clear,
    input held
  );

  modport store (
    input set_bits,
    input clear,
    output held
  );
endinterface

// file: shared/status_pkg.sv
/*
  Constants, command codes and field positions shared by the status
  reporting block and its event latch.
  Assumes a single clock and an asynchronous active-low power-on reset.
*/
package status_pkg;

  localparam int unsigned BYTE_W = 8;

  // Standard event bit positions
  localparam int unsigned EV_OPC = 0;
  localparam int unsigned EV_REQ_CTRL = 1;
  localparam int unsigned EV_QUERY_ERR = 2;
  localparam int unsigned EV_DEV_ERR = 3;
  localparam int unsigned EV_EXEC_ERR = 4;
  localparam int unsigned EV_CMD_ERR = 5;
  localparam int unsigned EV_USER_REQ = 6;
  localparam int unsigned EV_POWER_ON = 7;

  // Summary byte bit positions
  localparam int unsigned SB_MAV = 4;
  localparam int unsigned SB_ESB = 5;
  localparam int unsigned SB_RQS = 6;

  // Service request mask: bit 6 never stored
  localparam logic [7:0] SRQ_WRITE_MASK = 8'hbf;
  // Mask positions that take part in the request
  localparam logic [7:0] SRQ_ACTIVE_MASK = 8'h30;

  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
  localparam logic [7:0] SRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] BCD_ZERO = 12'h000;

  localparam logic [7:0] DEC_HUNDRED = 8'h64;
  localparam logic [7:0] DEC_TEN = 8'h0a;

  // Command codes on the command port
  typedef enum logic [3:0] {
    CMD_CLEAR_STATUS = 4'h1,
    CMD_EVENT_MASK_WR = 4'h2,
    CMD_EVENT_MASK_RD = 4'h3,
    CMD_EVENT_RD = 4'h4,
    CMD_SRQ_MASK_WR = 4'h5,
    CMD_SRQ_MASK_RD = 4'h6,
    CMD_STATUS_RD = 4'h7,
    CMD_OP_COMPLETE = 4'h8,
    CMD_RESET = 4'h9,
    CMD_DEVICE_CLEAR = 4'ha
  } cmd_t;

  typedef enum logic {
    OPC_IDLE,
    OPC_WAIT
  } opc_state_t;

endpackage
